// >>> shared/lvt_pkg.sv
// Constants for the seven-to-one serializing transmitter.
// Assumes a 100 MHz system clock and an external multiplier that supplies a 7x bit clock.
package lvt_pkg;
	localparam int LVT_LANES = 3;
	localparam int LVT_SLICE_BITS = 7;
	localparam int LVT_WORD_BITS = LVT_LANES * LVT_SLICE_BITS;
	localparam int LVT_SYNC_STAGES = 3;
	localparam int LVT_PHASE_W = 3;
	localparam logic [2:0] LVT_PHASE_FIRST = 3'h0;
	localparam logic [2:0] LVT_PHASE_LAST = 3'h6;
	localparam logic [2:0] LVT_CLK_HIGH_PHASES = 3'h4;
	localparam int LVT_WCLK_MIN_MHZ = 20;
	localparam int LVT_WCLK_MAX_MHZ = 68;
	localparam int LVT_SYS_CLK_HZ = 100_000_000;
	localparam int LVT_LOCK_TIME_MS = 1;
	localparam int LVT_LOCK_CYCLES = LVT_LOCK_TIME_MS * (LVT_SYS_CLK_HZ / 1000);
	localparam int LVT_OFF_TIME_NS = 250;
	localparam logic LVT_RST_BIT = 1'b0;
endpackage

// >>> core/lvt_lane.sv
// One serial lane: a parallel-load shift register driving a differential pair.
// Assumes load and clear come from logic on the same bit clock.
`timescale 1ns/10ps
`default_nettype none
module lvt_lane
	import lvt_pkg::*;
#(
	parameter int WIDTH = LVT_SLICE_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic clear,
	input wire logic load,
	input wire logic [WIDTH-1:0] word,
	// Differential pair
	output logic lane_pos,
	output logic lane_neg
);
	typedef struct packed {
		logic [WIDTH-1:0] sh;
		logic pos;
		logic neg;
	} lvt_lane_st_t;

	lvt_lane_st_t st_q;
	lvt_lane_st_t st_d;

	if (WIDTH < 2) begin : g_chk
		$error("lvt_lane needs at least two bits");
	end

	always_comb begin
		st_d = st_q;
		if (clear) begin
			st_d = '0;
		end else if (load) begin
			st_d.sh = {1'b0, word[WIDTH-1:1]};
			st_d.pos = word[0];
			st_d.neg = ~word[0];
		end else begin
			st_d.sh = {1'b0, st_q.sh[WIDTH-1:1]};
			st_d.pos = st_q.sh[0];
			st_d.neg = ~st_q.sh[0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign lane_pos = st_q.pos;
	assign lane_neg = st_q.neg;
endmodule
`default_nettype wire

// >>> core/lvt_serializer_tx.sv
// Seven-to-one serializing transmitter top level.
// Assumes bit_clk comes from a multiplier locked at seven times the word clock;
// sys_clk times the power-down sequencing and the lock wait.
`timescale 1ns/10ps
`default_nettype none
module lvt_serializer_tx
	import lvt_pkg::*;
#(
	parameter int LOCK_CYCLES = LVT_LOCK_CYCLES
) (
	// System clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Bit clock from the multiplier
	input wire logic bit_clk,
	// Parallel source side
	input wire logic parallel_word_clock,
	input wire logic [LVT_WORD_BITS-1:0] parallel_input,
	input wire logic power_down_clear_n,
	// Serial lanes
	output logic serial_lane0_pos,
	output logic serial_lane0_neg,
	output logic serial_lane1_pos,
	output logic serial_lane1_neg,
	output logic serial_lane2_pos,
	output logic serial_lane2_neg,
	// Forwarded clock lane
	output logic forwarded_link_clock_pos,
	output logic forwarded_link_clock_neg,
	// Driver enable, also marks lane data valid
	output logic lane_drive_en
);
	localparam int CNT_W = $clog2(LOCK_CYCLES + 1);

	if (LOCK_CYCLES < 1) begin : g_chk
		$error("LOCK_CYCLES must be at least one");
	end

	// The filters and the lane pins are written for these package values
	if (LVT_SYNC_STAGES != 3) begin : g_chk_sync
		$error("power-down and word clock filters need three stages");
	end
	if (LVT_LANES != 3 || LVT_WORD_BITS != LVT_LANES * LVT_SLICE_BITS) begin : g_chk_lanes
		$error("three lanes of one slice each are wired to the pins");
	end
	if (int'(LVT_PHASE_LAST) != LVT_SLICE_BITS - 1) begin : g_chk_phase
		$error("phase counter does not match the slice length");
	end
	if (LVT_CLK_HIGH_PHASES > LVT_PHASE_LAST) begin : g_chk_high
		$error("forwarded clock high time exceeds one word");
	end

	// System domain: power-down filter and lock wait
	typedef struct packed {
		logic [LVT_SYNC_STAGES-1:0] pd_s;
		logic pd_lvl;
		logic [CNT_W-1:0] cnt;
		logic en;
	} lvt_sys_st_t;

	lvt_sys_st_t sys_q;
	lvt_sys_st_t sys_d;

	always_comb begin
		sys_d = sys_q;
		sys_d.pd_s = {sys_q.pd_s[LVT_SYNC_STAGES-2:0], power_down_clear_n};
		if (sys_q.pd_s[1] == sys_q.pd_s[2]) begin
			sys_d.pd_lvl = sys_q.pd_s[2];
		end
		if (!sys_q.pd_lvl) begin
			sys_d.cnt = '0;
			sys_d.en = 1'b0;
		end else if (sys_q.cnt != CNT_W'(LOCK_CYCLES)) begin
			sys_d.cnt = sys_q.cnt + CNT_W'(1);
		end else begin
			sys_d.en = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sys_q <= '0;
		end else begin
			sys_q <= sys_d;
		end
	end

	// Link domain: word capture, phase counter, forwarded clock
	typedef struct packed {
		logic [LVT_SYNC_STAGES-1:0] wclk_s;
		logic [LVT_WORD_BITS-1:0] dat_s1;
		logic [LVT_WORD_BITS-1:0] dat_s2;
		logic [LVT_WORD_BITS-1:0] dat_s3;
		logic wclk_lvl;
		logic [LVT_WORD_BITS-1:0] hold;
		logic [1:0] en_s;
		logic [LVT_PHASE_W-1:0] phase;
		logic fclk_pos;
		logic fclk_neg;
		logic drive_en;
	} lvt_link_st_t;

	lvt_link_st_t lnk_q;
	lvt_link_st_t lnk_d;
	logic run;
	logic lane_load;
	logic lane_clear;

	always_comb begin
		lnk_d = lnk_q;
		lnk_d.wclk_s = {lnk_q.wclk_s[LVT_SYNC_STAGES-2:0], parallel_word_clock};
		lnk_d.dat_s1 = parallel_input;
		lnk_d.dat_s2 = lnk_q.dat_s1;
		lnk_d.dat_s3 = lnk_q.dat_s2;
		lnk_d.en_s = {lnk_q.en_s[0], sys_q.en};
		run = lnk_q.en_s[1];
		lane_clear = !run;
		lane_load = run && (!lnk_q.drive_en || lnk_q.phase == LVT_PHASE_LAST);
		// Data lags the clock sample by the same three stages, so the pair stays aligned
		if (lnk_q.wclk_s[1] == lnk_q.wclk_s[2] && lnk_q.wclk_s[2] != lnk_q.wclk_lvl) begin
			lnk_d.wclk_lvl = lnk_q.wclk_s[2];
			if (lnk_q.wclk_s[2]) begin
				lnk_d.hold = lnk_q.dat_s3;
			end
		end
		if (!run) begin
			lnk_d.hold = '0;
			lnk_d.phase = LVT_PHASE_FIRST;
			lnk_d.fclk_pos = 1'b0;
			lnk_d.fclk_neg = 1'b0;
			lnk_d.drive_en = 1'b0;
		end else begin
			if (lane_load) begin
				lnk_d.phase = LVT_PHASE_FIRST;
			end else begin
				lnk_d.phase = lnk_q.phase + 3'h1;
			end
			// High for four bit times, low for three: one period per word
			lnk_d.fclk_pos = lnk_d.phase < LVT_CLK_HIGH_PHASES;
			lnk_d.fclk_neg = !(lnk_d.phase < LVT_CLK_HIGH_PHASES);
			lnk_d.drive_en = 1'b1;
		end
	end

	always_ff @(posedge bit_clk or posedge rst) begin
		if (rst) begin
			lnk_q <= '0;
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// Lanes; lane k slot n carries input bit 7k+n
	logic [LVT_LANES-1:0] lane_pos;
	logic [LVT_LANES-1:0] lane_neg;

	for (genvar k = 0; k < LVT_LANES; k++) begin : g_lane
		lvt_lane #(
			.WIDTH(LVT_SLICE_BITS)
		) u_lane (
			.clk(bit_clk),
			.rst(rst),
			.clear(lane_clear),
			.load(lane_load),
			.word(lnk_q.hold[k*LVT_SLICE_BITS +: LVT_SLICE_BITS]),
			.lane_pos(lane_pos[k]),
			.lane_neg(lane_neg[k])
		);
	end

	// Four differential lanes leave the block
	assign serial_lane0_pos = lane_pos[0];
	assign serial_lane0_neg = lane_neg[0];
	assign serial_lane1_pos = lane_pos[1];
	assign serial_lane1_neg = lane_neg[1];
	assign serial_lane2_pos = lane_pos[2];
	assign serial_lane2_neg = lane_neg[2];
	assign forwarded_link_clock_pos = lnk_q.fclk_pos;
	assign forwarded_link_clock_neg = lnk_q.fclk_neg;
	assign lane_drive_en = lnk_q.drive_en;
endmodule
`default_nettype wire

// >>> verification/lvt_monitor.sv
// Checker for the serializer's lane timing and power-down behaviour.
// Assumes a bind onto the transmitter top, ports matched by name.
`timescale 1ns/10ps
`default_nettype none
module lvt_monitor #(
	parameter int LOCK_CYCLES = 20
) (
	// Clocks and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic bit_clk,
	// Watched pins
	input wire logic power_down_clear_n,
	input wire logic serial_lane0_pos,
	input wire logic serial_lane0_neg,
	input wire logic serial_lane1_pos,
	input wire logic serial_lane1_neg,
	input wire logic serial_lane2_pos,
	input wire logic serial_lane2_neg,
	input wire logic forwarded_link_clock_pos,
	input wire logic forwarded_link_clock_neg,
	input wire logic lane_drive_en
);
	lane_pair_a: assert property (@(posedge bit_clk) disable iff (rst)
		lane_drive_en |-> serial_lane0_neg != serial_lane0_pos) else $error("lane pair equal");
	upper_pairs_a: assert property (@(posedge bit_clk) disable iff (rst)
		lane_drive_en |-> serial_lane1_neg != serial_lane1_pos
		&& serial_lane2_neg != serial_lane2_pos) else $error("upper lane pair equal");
	off_upper_a: assert property (@(posedge bit_clk) disable iff (rst)
		!lane_drive_en |-> !(serial_lane1_pos | serial_lane1_neg | serial_lane2_neg))
		else $error("off upper lanes active");
	clk_pair_a: assert property (@(posedge bit_clk) disable iff (rst)
		lane_drive_en |-> forwarded_link_clock_neg == !forwarded_link_clock_pos)
		else $error("clock pair equal");
	off_zero_a: assert property (@(posedge bit_clk) disable iff (rst)
		!lane_drive_en |-> !(serial_lane0_pos | serial_lane0_neg | serial_lane2_pos
		| forwarded_link_clock_pos | forwarded_link_clock_neg)) else $error("off lanes active");
	// Disabled when drivers drop so a power-down mid-word is not a false alarm
	clk_high_a: assert property (@(posedge bit_clk) disable iff (rst || !lane_drive_en)
		$rose(forwarded_link_clock_pos) |-> forwarded_link_clock_pos[*4] ##1
		!forwarded_link_clock_pos) else $error("clock high time wrong");
	clk_low_a: assert property (@(posedge bit_clk) disable iff (rst || !lane_drive_en)
		$fell(forwarded_link_clock_pos) |-> !forwarded_link_clock_pos[*3] ##1
		forwarded_link_clock_pos) else $error("clock low time wrong");
	first_phase_a: assert property (@(posedge bit_clk) disable iff (rst)
		$rose(lane_drive_en) |-> forwarded_link_clock_pos) else $error("first phase wrong");
	pd_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(power_down_clear_n) |-> ##[1:25] !lane_drive_en && !forwarded_link_clock_pos)
		else $error("power-down too slow");
	lock_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(power_down_clear_n) |-> ##LOCK_CYCLES !lane_drive_en ##[1:40] lane_drive_en)
		else $error("lock wait wrong");
	cover property (@(posedge bit_clk) $rose(lane_drive_en));
	cover property (@(posedge bit_clk) $fell(lane_drive_en));
	cover property (@(posedge bit_clk) lane_drive_en && $rose(forwarded_link_clock_pos));
endmodule
`default_nettype wire

// >>> verification/lvt_rx_model.sv
// Behavioural seven-to-one receiver rebuilding the parallel word.
// Assumes lanes and forwarded clock sampled on the bit clock.
`timescale 1ns/10ps
`default_nettype none
module lvt_rx_model
	import lvt_pkg::*;
(
	// Link side
	input wire logic bit_clk,
	input wire logic en,
	input wire logic fclk,
	input wire logic [LVT_LANES-1:0] lane,
	// Recovered word
	output logic [LVT_WORD_BITS-1:0] word,
	output logic valid
);
	logic fclk_q = 1'b0;
	logic [LVT_WORD_BITS-1:0] acc = 21'h0;
	int slot = 7;
	// Slots restart at each clock rise, so one lost bit cannot skew later words
	always @(posedge bit_clk) begin
		valid <= 1'b0;
		fclk_q <= fclk;
		if (!en) begin
			slot = 7;
		end else begin
			if (fclk && !fclk_q) begin
				slot = 0;
			end
			if (slot < 7) begin
				for (int k = 0; k < 3; k++) begin
					acc[7 * k + slot] = lane[k];
				end
				if (slot == 6) begin
					word <= acc;
					valid <= 1'b1;
				end
				slot = slot + 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Testbench for the serializing transmitter with a receiver model.
// Assumes the word clock is the bit clock divided by seven.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import lvt_pkg::*;
	localparam int LOCK_CYCLES = 20;
	logic sys_clk = 1'b0;
	logic bit_clk = 1'b0;
	logic rst = 1'b1;
	logic wclk = 1'b0;
	logic pd_n = 1'b1;
	logic chk = 1'b0;
	logic [LVT_WORD_BITS-1:0] din = 21'h0;
	logic [LVT_WORD_BITS-1:0] exp_w = 21'h0;
	logic [LVT_WORD_BITS-1:0] rx_w;
	logic [2:0] lp, ln;
	logic fp, fn, en, rx_v;
	logic first_w = 1'b1;
	int wph = 0, miscompares = 0, comparisons = 0, cyc = 0, seed = 32'hd396;
	always #5 sys_clk = ~sys_clk;
	// Odd offset keeps the two clocks from ever sharing an edge
	initial begin
		#1.3;
		forever #3 bit_clk = ~bit_clk;
	end
	always @(posedge bit_clk) begin
		wph <= (wph + 1) % 7;
		wclk <= (wph < 3);
	end
	lvt_serializer_tx #(.LOCK_CYCLES(LOCK_CYCLES)) dut (.sys_clk(sys_clk), .rst(rst),
		.bit_clk(bit_clk), .parallel_word_clock(wclk), .parallel_input(din),
		.power_down_clear_n(pd_n), .serial_lane0_pos(lp[0]), .serial_lane0_neg(ln[0]),
		.serial_lane1_pos(lp[1]), .serial_lane1_neg(ln[1]), .serial_lane2_pos(lp[2]),
		.serial_lane2_neg(ln[2]), .forwarded_link_clock_pos(fp),
		.forwarded_link_clock_neg(fn), .lane_drive_en(en));
	lvt_rx_model rx (.bit_clk(bit_clk), .en(en), .fclk(fp), .lane(lp), .word(rx_w), .valid(rx_v));
	task automatic check(input string nm, input logic [20:0] e, input logic [20:0] s);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize;
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wait_en;
		int n;
		n = 0;
		while (en !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		check("lock", 21'h1, {20'h0, en});
	endtask
	// Guard time covers sync stages plus one word in flight
	task automatic send(input logic [20:0] w);
		chk = 1'b0;
		din <= w;
		repeat (15) @(posedge sys_clk);
		exp_w = w;
		chk = 1'b1;
		repeat (30) @(posedge sys_clk);
	endtask
	always @(posedge bit_clk) begin
		if (chk && rx_v === 1'b1) begin
			check("rx_word", exp_w, rx_w);
		end
	end
	// The first word after lock comes from the cleared holding register
	always @(posedge bit_clk) begin
		if (en !== 1'b1) begin
			first_w <= 1'b1;
		end else if (rx_v === 1'b1) begin
			if (first_w) begin
				check("first_word", 21'h0, rx_w);
			end
			first_w <= 1'b0;
		end
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		wait_en();
		for (int i = 0; i < 8; i++) begin
			send(i == 0 ? 21'h0 : i == 1 ? 21'h1FFFFF : 21'($random(seed)));
		end
		chk = 1'b0;
		pd_n <= 1'b0;
		repeat (25) @(posedge sys_clk);
		check("off_pins", 21'h0, {12'h0, en, fp, fn, lp, ln});
		pd_n <= 1'b1;
		wait_en();
		send(21'($random(seed)));
		summarize();
	end
endmodule
bind lvt_serializer_tx lvt_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) mon (.*);
`default_nettype wire
